// File: dv/rod_afe_model.sv
// Purpose: analog front end stand-in driving rf samples and offset measurements
// Assumes: bench sets amplitude and raw offset
// Notes: measured offset line toggles between valid pulses
`timescale 1ns/10ps
`default_nettype none
module rod_afe_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic signed [5:0] corr,
  input wire logic [7:0] amp,
  input wire logic signed [7:0] base_off,
  input wire logic meas_on,
  output logic signed [7:0] rf_sample,
  output logic signed [7:0] offset_meas,
  output logic offset_meas_valid
);
  logic [1:0] ph;
  logic signed [7:0] half;
  assign half = $signed({1'b0, amp[7:1]});
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 2'h0;
      rf_sample <= 8'h00;
      offset_meas <= 8'h00;
      offset_meas_valid <= 1'b0;
    end else begin
      ph <= ph + 2'h1;
      rf_sample <= ph[0] ? half : -half;
      offset_meas_valid <= meas_on && ph == 2'h3;
      // correction adds to the offset seen at the converter
      offset_meas <= (meas_on && ph == 2'h3) ? base_off + 8'(corr) : ~offset_meas;
    end
  end
endmodule : rod_afe_model
`default_nettype wire

// File: dv/tb_top.sv
// Purpose: self-checking bench of the offset loop and defect block
// Assumes: one wait state per bus access
// Notes: correction modelled in integers; defect timing counted at negedges
`timescale 1ns/10ps
`default_nettype none
`include "rod_map.svh"
module tb_top;
  localparam longint U = `ROD_UNIT;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic signed [7:0] rf_sample, offset_meas;
  logic signed [7:0] base_off = 8'h00;
  logic [7:0] amp = 8'h00;
  logic offset_meas_valid;
  logic meas_on = 1'b0;
  logic pll_in_lock = 1'b1;
  logic signed [5:0] corr;
  logic [4:0] holds;
  logic pfb, sfb, draw, dproc, dev, gle, gls;
  logic pend = 1'b0;
  logic [15:0] lfsr = 16'h47A3;
  int fail_count = 0;
  int n_tests = 0;
  int m_win = 8, m_inv = 0, m_bw = 0, m_slow = 0, m_lo = -32, m_hi = 31, m_corr = 0, m_on = 0;
  int ev_n = 0, pf_n = 0, sf_n = 0;
  longint m_int = 0;

  always #4 clock = ~clock;

  rod_afe_model afe (.clock(clock), .rst_n(rst_n), .corr(corr), .amp(amp),
    .base_off(base_off), .meas_on(meas_on), .rf_sample(rf_sample),
    .offset_meas(offset_meas), .offset_meas_valid(offset_meas_valid));

  rod_offset_defect dut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rf_sample(rf_sample), .offset_meas(offset_meas),
    .offset_meas_valid(offset_meas_valid), .pll_in_lock(pll_in_lock),
    .offset_correction_value(corr), .gain_loop_enable(gle), .gain_loop_slow(gls),
    .hold_pll(holds[0]), .hold_slicer(holds[1]), .hold_gain(holds[2]),
    .hold_offset(holds[3]), .hold_hpf(holds[4]), .pll_fast_bw(pfb),
    .slicer_fast_bw(sfb), .defect_raw(draw), .defect_processed(dproc),
    .defect_event(dev));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic fail_to();
    fail_count++;
    $display("wrong value at %0t: wait ran out", $time);
    print_verdict();
  endtask : fail_to

  // integer model of integrator, hysteresis and clamp
  always @(posedge clock) begin
    int d;
    pend <= offset_meas_valid && m_on;
    if (offset_meas_valid && m_on) begin
      d = offset_meas > m_win ? -1 : offset_meas < -m_win ? 1 : 0;
      if (m_inv) d = -d;
      m_int = m_int + d * (longint'(1) << (m_slow ? m_bw : m_bw + 7));
      if (m_int >= (m_corr + 1) * U && m_corr < m_hi) m_corr++;
      else if (m_int <= (m_corr - 1) * U && m_corr > m_lo) m_corr--;
    end
  end

  always @(negedge clock) begin
    if (pend) check(corr, 6'(m_corr), "offset correction");
    ev_n += (dev === 1'b1);
    pf_n += (pfb === 1'b1);
    sf_n += (sfb === 1'b1);
  end

  task automatic av(input logic w, input logic [5:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    i = 0;
    do begin
      @(posedge clock);
      i++;
      if (i > 20) fail_to();
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    av(1'b1, a, d, q);
    @(negedge clock);
  endtask : wr

  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    av(1'b0, a, 32'h0000_0000, q);
    check(q, e, "register read");
  endtask : rdc

  task automatic wait_for(ref logic s, input logic v, input int lim, output int n);
    for (n = 0; s !== v; n++) begin
      if (n >= lim) fail_to();
      @(negedge clock);
    end
  endtask : wait_for

  task automatic meas(input int p);
    @(posedge clock);
    meas_on <= 1'b1;
    repeat (4 * p) @(posedge clock);
    meas_on <= 1'b0;
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask : meas

  task automatic set_corr(input int v);
    wr(`ROD_OFF_CORR, 32'(v));
    m_corr = v;
    m_int = v * U;
  endtask : set_corr

  task automatic defect(input logic on, input int gap);
    int n;
    @(posedge clock);
    amp <= on ? 8'h00 : 8'h64;
    wait_for(draw, on, 2000, n);
    wait_for(dproc, on, 200, n);
    check(n, gap, "defect edge delay");
  endtask : defect

  initial begin
    int i;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(negedge clock);
    check(draw, 1'b1, "raw defect at start");
    check(dproc, 1'b1, "processed defect at start");
    rdc(`ROD_OFF_WINDOW, 32'(`ROD_RST_WINDOW));
    rdc(`ROD_OFF_LIMITS, {18'h0, `ROD_RST_LIM_HI, 2'h0, `ROD_RST_LIM_LO});
    rdc(`ROD_OFF_THRES, {16'h0, `ROD_RST_THR_HI, `ROD_RST_THR_LO});
    rdc(`ROD_OFF_DELAYS, 32'h0000_0000);
    wr(6'h30, 32'hFFFF_FFFF);
    rdc(6'h30, 32'h0000_0000);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      wr(`ROD_OFF_CTRL, {29'h0, i[1], 1'b0, i[0]});
      check(gle, i[0], "gain enable");
      check(gls, i[1], "gain slow");
    end
    for (i = 0; i < 5; i++) begin
      wr(`ROD_OFF_HOLDEN, 32'h1 << i);
      check(holds, 32'h1 << i, "hold enables");
    end
    wr(`ROD_OFF_CTRL, 32'h10);
    @(posedge clock);
    pll_in_lock <= 1'b0;
    wr(`ROD_OFF_HOLDEN, 32'h1F);
    check(holds, 5'h13, "hold without lock");
    @(posedge clock);
    pll_in_lock <= 1'b1;
    @(negedge clock);
    check(holds, 5'h1F, "hold with lock");
    defect(1'b0, 0);
    wr(`ROD_OFF_HOLDEN, 32'h71F);
    check(holds, 5'h13, "forced holds");
    wr(`ROD_OFF_HOLDEN, 32'h1F);
    check(holds, 5'h00, "no defect no hold");
    $display("test holds done");
    wr(`ROD_OFF_CTRL, 32'h2);
    wr(`ROD_OFF_LIMITS, 32'h0000_053B);
    m_lo = -5;
    m_hi = 5;
    wr(`ROD_OFF_BW, 32'hF);
    m_bw = 15;
    m_on = 1;
    set_corr(0);
    lfsr = lfsr_next(lfsr);
    base_off <= 8'h14 + 8'(lfsr[3:0]);
    meas(3);
    check(corr, 6'sh3D, "offset above window");
    meas(9);
    check(corr, 6'sh3B, "lower limit");
    // window kept at plus or minus 8
    wr(`ROD_OFF_WINDOW, 32'h108);
    m_inv = 1;
    wr(`ROD_OFF_BW, 32'hE);
    m_bw = 14;
    set_corr(0);
    meas(1);
    check(corr, 6'sh00, "half step held");
    meas(1);
    check(corr, 6'sh01, "inverted direction");
    meas(12);
    check(corr, 6'sh05, "upper limit");
    wr(`ROD_OFF_CTRL, 32'hA);
    wr(`ROD_OFF_BW, 32'hF);
    m_bw = 15;
    m_slow = 1;
    set_corr(0);
    meas(127);
    check(corr, 6'sh00, "slow step pending");
    meas(1);
    check(corr, 6'sh01, "slow step");
    m_on = 0;
    wr(`ROD_OFF_CTRL, 32'h2);
    wr(`ROD_OFF_HOLDEN, 32'h8);
    defect(1'b1, 0);
    meas(8);
    check(corr, 6'sh01, "held loop");
    defect(1'b0, 0);
    wr(`ROD_OFF_CTRL, 32'h0);
    meas(8);
    check(corr, 6'sh01, "disabled loop");
    $display("test offset done");
    @(posedge clock);
    amp <= 8'h18;
    repeat (300) @(negedge clock);
    check(draw, 1'b0, "amplitude between thresholds");
    defect(1'b1, 0);
    @(posedge clock);
    amp <= 8'h18;
    repeat (300) @(negedge clock);
    check(draw, 1'b1, "amplitude between thresholds");
    defect(1'b0, 0);
    wr(`ROD_OFF_DELAYS, 32'h001E_0014);
    wr(`ROD_OFF_FAST, 32'h0001_000A);
    for (i = 0; i < 5; i++) begin
      wr(`ROD_OFF_MASK, i < 4 ? 32'h1 << i : 32'h0);
      ev_n = 0;
      pf_n = 0;
      sf_n = 0;
      defect(1'b1, 20);
      defect(1'b0, 30);
      repeat (40) @(negedge clock);
      check(ev_n, i < 4, "defect events");
      check(pf_n, 10, "fast window length");
      check(sf_n, 0, "slicer fast unselected");
    end
    $display("test defect done");
    wr(`ROD_OFF_PEAKBW, 32'h0000_0015);
    rdc(`ROD_OFF_PEAKBW, 32'h0000_0015);
    defect(1'b1, 20);
    defect(1'b0, 30);
    $display("test peak filter done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire

// File: hw/rod_offset_defect.sv
// Purpose: offset regulation loop, loop enables and amplitude defect detector with holds
// Assumes: rf_sample, offset_meas and pll_in_lock come from logic on the same clock
// Notes: Avalon-MM slave, one wait state on every access
//
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "rod_map.svh"

module rod_offset_defect (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic signed [7:0] rf_sample,
  input wire logic signed [7:0] offset_meas,
  input wire logic offset_meas_valid,
  input wire logic pll_in_lock,
  output logic signed [5:0] offset_correction_value,
  output logic gain_loop_enable,
  output logic gain_loop_slow,
  output logic hold_pll,
  output logic hold_slicer,
  output logic hold_gain,
  output logic hold_offset,
  output logic hold_hpf,
  output logic pll_fast_bw,
  output logic slicer_fast_bw,
  output logic defect_raw,
  output logic defect_processed,
  output logic defect_event
);

  rod_pkg::rod_state_t s_reg;
  rod_pkg::rod_state_t s_next;

  logic req;
  logic wr_en;
  logic hold_allow;
  logic off_run;
  logic above;
  logic below;
  logic step_up;
  logic step_dn;
  logic [7:0] neg_win;
  logic signed [31:0] amt;
  logic signed [31:0] int_lo;
  logic signed [31:0] int_hi;
  logic signed [31:0] corr32;
  logic signed [31:0] integ_t;
  logic signed [16:0] nf_diff;
  logic signed [16:0] nf_sum;
  logic signed [31:0] pk_in;
  logic signed [31:0] max_dec;
  logic signed [31:0] min_dec;
  logic signed [31:0] amp32;
  logic [8:0] amp;
  logic [4:0] decay_m;
  logic raw_t;
  logic [15:0] dly_sel;
  logic [31:0] rd_mux;
  logic [3:0] ev;

  assign req = avs_read | avs_write;
  assign wr_en = avs_write & s_reg.ack;
  assign avs_waitrequest = req & ~s_reg.ack;
  assign avs_readdata = s_reg.rdata;

  assign hold_allow = ~(s_reg.ctrl.no_hold_unlock & ~pll_in_lock);
  assign hold_pll = s_reg.force_hold[0] | (s_reg.proc & s_reg.hold_en[0]);
  assign hold_slicer = s_reg.force_hold[1] | (s_reg.proc & s_reg.hold_en[1]);
  assign hold_hpf = s_reg.force_hold[2] | (s_reg.proc & s_reg.hold_en[4]);
  assign hold_gain = s_reg.proc & s_reg.hold_en[2] & hold_allow;
  assign hold_offset = s_reg.proc & s_reg.hold_en[3] & hold_allow;
  assign gain_loop_enable = s_reg.ctrl.gain_en;
  assign gain_loop_slow = s_reg.ctrl.gain_slow;
  assign pll_fast_bw = (s_reg.fast_cnt != 16'h0000) & s_reg.fast_sel[0];
  assign slicer_fast_bw = (s_reg.fast_cnt != 16'h0000) & s_reg.fast_sel[1];
  assign offset_correction_value = s_reg.corr;
  assign defect_raw = s_reg.raw;
  assign defect_processed = s_reg.proc;
  assign defect_event = s_reg.event_pulse;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case ({avs_address[5:2], 2'b00})
      `ROD_OFF_CTRL: rd_mux = {27'h0, s_reg.ctrl};
      `ROD_OFF_WINDOW: rd_mux = {23'h0, s_reg.inv, 1'b0, s_reg.win};
      `ROD_OFF_CORR: rd_mux = {26'h0, s_reg.corr};
      `ROD_OFF_BW: rd_mux = {28'h0, s_reg.bw};
      `ROD_OFF_LIMITS: rd_mux = {18'h0, s_reg.lim_hi, 2'b00, s_reg.lim_lo};
      `ROD_OFF_PEAKBW: rd_mux = {24'h0, s_reg.nf_code, s_reg.decay_code};
      `ROD_OFF_THRES: rd_mux = {16'h0, s_reg.thr_hi, s_reg.thr_lo};
      `ROD_OFF_HOLDEN: rd_mux = {21'h0, s_reg.force_hold, 3'b000, s_reg.hold_en};
      `ROD_OFF_DELAYS: rd_mux = {s_reg.stop_dly, s_reg.start_dly};
      `ROD_OFF_FAST: rd_mux = {14'h0, s_reg.fast_sel, s_reg.fast_len};
      `ROD_OFF_MASK: rd_mux = {28'h0, s_reg.int_mask};
      `ROD_OFF_STATUS: rd_mux = {15'h0, amp, 5'h00, pll_fast_bw | slicer_fast_bw,
                                 s_reg.proc, s_reg.raw};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    // bus handshake: answer on the second cycle of each request
    s_next.ack = req & ~s_reg.ack;
    if (req & ~s_reg.ack) begin
      s_next.rdata = avs_read ? rd_mux : 32'h0000_0000;
    end

    // offset loop
    neg_win = 8'h00 - {1'b0, s_reg.win};
    above = offset_meas > $signed({1'b0, s_reg.win});
    below = offset_meas < $signed(neg_win);
    step_up = s_reg.inv ? above : below;
    step_dn = s_reg.inv ? below : above;
    amt = s_reg.ctrl.off_slow ? $signed(`ROD_SLOW_STEP << s_reg.bw)
                              : $signed(`ROD_FAST_STEP << s_reg.bw);
    int_lo = {{4{s_reg.lim_lo[5]}}, s_reg.lim_lo, 22'h000000};
    int_hi = {{4{s_reg.lim_hi[5]}}, s_reg.lim_hi, 22'h000000};
    corr32 = {{4{s_reg.corr[5]}}, s_reg.corr, 22'h000000};
    off_run = s_reg.ctrl.off_en & ~hold_offset;
    integ_t = s_reg.integ;
    if (off_run & offset_meas_valid) begin
      if (step_up) begin
        integ_t = s_reg.integ + amt;
      end else if (step_dn) begin
        integ_t = s_reg.integ - amt;
      end
    end
    if (off_run) begin
      if (integ_t > int_hi) begin
        integ_t = int_hi;
      end else if (integ_t < int_lo) begin
        integ_t = int_lo;
      end
      s_next.integ = integ_t;
      if (integ_t >= corr32 + $signed(`ROD_UNIT)) begin
        s_next.corr = s_reg.corr + 6'sh01;
      end else if (integ_t <= corr32 - $signed(`ROD_UNIT)) begin
        s_next.corr = s_reg.corr - 6'sh01;
      end
      if (s_next.corr > s_reg.lim_hi) begin
        s_next.corr = s_reg.lim_hi;
      end else if (s_next.corr < s_reg.lim_lo) begin
        s_next.corr = s_reg.lim_lo;
      end
    end

    nf_diff = {rf_sample[7], rf_sample, 8'h00} - {s_reg.nf[15], s_reg.nf};
    nf_sum = $signed({s_reg.nf[15], s_reg.nf}) + (nf_diff >>> s_reg.nf_code);
    s_next.nf = nf_sum[15:0];
    decay_m = {1'b0, s_reg.decay_code} + `ROD_DECAY_BASE;
    pk_in = {{2{s_reg.nf[15]}}, s_reg.nf, 14'h0000};
    max_dec = s_reg.pk_max - ((s_reg.pk_max - $signed(`ROD_PK_FLOOR)) >>> decay_m);
    min_dec = s_reg.pk_min + (($signed(`ROD_PK_CEIL) - s_reg.pk_min) >>> decay_m);
    s_next.pk_max = (pk_in > s_reg.pk_max) ? pk_in : max_dec;
    s_next.pk_min = (pk_in < s_reg.pk_min) ? pk_in : min_dec;
    amp32 = s_reg.pk_max - s_reg.pk_min;
    amp = amp32[31] ? 9'h000 : amp32[30:22];

    raw_t = s_reg.raw;
    if (amp < {1'b0, s_reg.thr_lo}) begin
      raw_t = 1'b1;
    end else if (amp > {1'b0, s_reg.thr_hi}) begin
      raw_t = 1'b0;
    end
    s_next.raw = raw_t;

    dly_sel = raw_t ? s_reg.start_dly : s_reg.stop_dly;
    s_next.dcnt = 16'h0000;
    if (raw_t != s_reg.proc) begin
      if (s_reg.dcnt >= dly_sel) begin
        s_next.proc = raw_t;
      end else begin
        s_next.dcnt = s_reg.dcnt + 16'h0001;
      end
    end

    if (s_reg.proc & ~s_next.proc) begin
      s_next.fast_cnt = s_reg.fast_len;
    end else if (s_next.proc) begin
      s_next.fast_cnt = 16'h0000;
    end else if (s_reg.fast_cnt != 16'h0000) begin
      s_next.fast_cnt = s_reg.fast_cnt - 16'h0001;
    end

    ev = {~s_next.proc & s_reg.proc, s_next.proc & ~s_reg.proc,
          ~raw_t & s_reg.raw, raw_t & ~s_reg.raw};
    s_next.event_pulse = |(ev & s_reg.int_mask);

    if (wr_en) begin
      case ({avs_address[5:2], 2'b00})
        `ROD_OFF_CTRL: s_next.ctrl = avs_writedata[4:0];
        `ROD_OFF_WINDOW: begin
          s_next.win = avs_writedata[6:0];
          s_next.inv = avs_writedata[8];
        end
        `ROD_OFF_CORR: begin
          s_next.corr = avs_writedata[5:0];
          s_next.integ = {{4{avs_writedata[5]}}, avs_writedata[5:0], 22'h000000};
        end
        `ROD_OFF_BW: s_next.bw = avs_writedata[3:0];
        `ROD_OFF_LIMITS: begin
          s_next.lim_lo = avs_writedata[5:0];
          s_next.lim_hi = avs_writedata[13:8];
        end
        `ROD_OFF_PEAKBW: begin
          s_next.decay_code = avs_writedata[3:0];
          s_next.nf_code = avs_writedata[7:4];
        end
        `ROD_OFF_THRES: begin
          s_next.thr_lo = avs_writedata[7:0];
          s_next.thr_hi = avs_writedata[15:8];
        end
        `ROD_OFF_HOLDEN: begin
          s_next.hold_en = avs_writedata[4:0];
          s_next.force_hold = avs_writedata[10:8];
        end
        `ROD_OFF_DELAYS: begin
          s_next.start_dly = avs_writedata[15:0];
          s_next.stop_dly = avs_writedata[31:16];
        end
        `ROD_OFF_FAST: begin
          s_next.fast_len = avs_writedata[15:0];
          s_next.fast_sel = avs_writedata[17:16];
        end
        `ROD_OFF_MASK: s_next.int_mask = avs_writedata[3:0];
        default: s_next.ack = s_next.ack;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.win <= `ROD_RST_WINDOW;
      s_reg.lim_lo <= `ROD_RST_LIM_LO;
      s_reg.lim_hi <= `ROD_RST_LIM_HI;
      s_reg.thr_lo <= `ROD_RST_THR_LO;
      s_reg.thr_hi <= `ROD_RST_THR_HI;
    end else begin
      s_reg <= s_next;
    end
  end

  logic corr_wr;
  assign corr_wr = wr_en & ({avs_address[5:2], 2'b00} == `ROD_OFF_CORR);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  off_direction_a: assert property (
    (offset_meas_valid & off_run & ~corr_wr & step_dn & (s_reg.integ > int_lo + amt))
    |=> s_reg.integ == $past(s_reg.integ) - $past(amt))
    else $error("offset integrator did not step down");

  off_polarity_a: assert property (
    (offset_meas_valid & off_run & ~corr_wr & s_reg.inv & above
     & (s_reg.integ < int_hi - amt)) |=> s_reg.integ > $past(s_reg.integ))
    else $error("inverted loop did not step up");

  corr_step_a: assert property (
    (off_run & ~corr_wr & (s_reg.integ < corr32 + $signed(`ROD_UNIT))
     & (s_reg.integ > corr32 - $signed(`ROD_UNIT)) & ~offset_meas_valid
     & (s_reg.corr <= s_reg.lim_hi) & (s_reg.corr >= s_reg.lim_lo))
    |=> $stable(s_reg.corr))
    else $error("correction moved inside hysteresis band");

  corr_clamp_a: assert property (
    (off_run & ~corr_wr & (s_reg.lim_lo <= s_reg.lim_hi))
    |=> (s_reg.corr <= $past(s_reg.lim_hi)) && (s_reg.corr >= $past(s_reg.lim_lo)))
    else $error("correction outside limits");

  off_hold_a: assert property (
    (hold_offset & ~corr_wr) |=> $stable(s_reg.corr) && $stable(s_reg.integ))
    else $error("offset loop moved during hold");

  nolock_a: assert property (
    (s_reg.ctrl.no_hold_unlock & ~pll_in_lock) |-> ~hold_gain && ~hold_offset)
    else $error("loop held while pll unlocked");

  defect_set_a: assert property (
    (amp < {1'b0, s_reg.thr_lo}) |=> s_reg.raw)
    else $error("raw defect not raised below low threshold");

  zero_delay_a: assert property (
    ((s_reg.start_dly == 16'h0000) && (s_reg.stop_dly == 16'h0000)) [*2]
    |-> s_reg.proc == $past(s_reg.raw) || s_reg.proc == s_reg.raw)
    else $error("processed defect lags with zero delays");

  start_delay_a: assert property (
    $rose(s_reg.proc) |-> $past(s_reg.dcnt) >= $past(s_reg.start_dly))
    else $error("processed defect rose before start delay");

  fast_open_a: assert property (
    ($fell(s_reg.proc) && s_reg.fast_len != 16'h0000 && s_reg.fast_sel[0])
    |-> pll_fast_bw ##1 1'b1)
    else $error("fast window did not open after defect");

  hold_map_a: assert property (
    (s_reg.proc & s_reg.hold_en[0]) |-> hold_pll)
    else $error("pll not held in defect");

  bus_wait_a: assert property (
    (req & ~s_reg.ack) |-> avs_waitrequest ##1 (!req || !avs_waitrequest))
    else $error("waitrequest sequence broken");

  peak_attack_a: assert property (
    (pk_in > s_reg.pk_max) |=> s_reg.pk_max == $past(pk_in))
    else $error("maximum peak did not take new extreme");

  defect_clear_a: assert property (
    (amp > {1'b0, s_reg.thr_hi}) && (amp >= {1'b0, s_reg.thr_lo}) |=> !s_reg.raw)
    else $error("raw defect not cleared above high threshold");

  raw_hold_a: assert property (
    (amp >= {1'b0, s_reg.thr_lo}) && (amp <= {1'b0, s_reg.thr_hi})
    |=> s_reg.raw == $past(s_reg.raw))
    else $error("raw defect changed inside hysteresis band");

  stop_delay_a: assert property (
    $fell(s_reg.proc) |-> $past(s_reg.dcnt) >= $past(s_reg.stop_dly))
    else $error("processed defect fell before stop delay");

  slow_ratio_a: assert property (
    s_reg.ctrl.off_slow |-> {amt[24:0], 7'h00} == (`ROD_FAST_STEP << s_reg.bw))
    else $error("slow step is not fast step over 128");

  event_mask_a: assert property (
    (s_reg.int_mask == 4'h0) |=> !defect_event)
    else $error("event raised while all masked");

  fast_cut_a: assert property (
    s_reg.proc |-> !pll_fast_bw && !slicer_fast_bw)
    else $error("fast window open during defect");

  force_hold_a: assert property (
    (s_reg.force_hold == 3'b111) |-> hold_pll && hold_slicer && hold_hpf)
    else $error("forced hold not applied");

  off_disable_a: assert property (
    (!s_reg.ctrl.off_en & ~corr_wr) |=> $stable(s_reg.integ) && $stable(s_reg.corr))
    else $error("disabled offset loop moved");

  corr_write_a: assert property (
    corr_wr |=> s_reg.corr == $past(avs_writedata[5:0]))
    else $error("correction write lost");

  proc_rise_c: cover property ($rose(s_reg.proc));
  fast_end_c: cover property ($fell(pll_fast_bw) && !s_reg.proc);
  corr_up_c: cover property (off_run && s_reg.corr == $past(s_reg.corr) + 6'sh01);
  event_c: cover property (defect_event);
  hold_off_c: cover property (hold_offset && offset_meas_valid);

endmodule : rod_offset_defect
`default_nettype wire

// File: pkg/rod_map.svh
// Purpose: register map, reset values and loop constants of the offset loop and defect block
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes: offsets and reset values below are local choices
`ifndef ROD_MAP_SVH
`define ROD_MAP_SVH

`define ROD_OFF_CTRL 6'h00
`define ROD_OFF_WINDOW 6'h04
`define ROD_OFF_CORR 6'h08
`define ROD_OFF_BW 6'h0C
`define ROD_OFF_LIMITS 6'h10
`define ROD_OFF_PEAKBW 6'h14
`define ROD_OFF_THRES 6'h18
`define ROD_OFF_HOLDEN 6'h1C
`define ROD_OFF_DELAYS 6'h20
`define ROD_OFF_FAST 6'h24
`define ROD_OFF_MASK 6'h28
`define ROD_OFF_STATUS 6'h2C

`define ROD_RST_WINDOW 7'h08
`define ROD_RST_LIM_LO 6'h20
`define ROD_RST_LIM_HI 6'h1F
`define ROD_RST_THR_LO 8'h10
`define ROD_RST_THR_HI 8'h20
`define ROD_DECAY_BASE 5'h06
`define ROD_SLOW_STEP 32'h0000_0001
`define ROD_FAST_STEP 32'h0000_0080
`define ROD_UNIT 32'h0040_0000
`define ROD_PK_FLOOR 32'hE000_0000
`define ROD_PK_CEIL 32'h1FFF_FFFF

`endif

// File: pkg/rod_pkg.sv
// Purpose: types of the offset loop and defect block
// Assumes: constants come from rod_map.svh
// Notes: whole module state is one packed struct
`default_nettype none
package rod_pkg;

  typedef struct packed {
    logic no_hold_unlock;
    logic off_slow;
    logic gain_slow;
    logic off_en;
    logic gain_en;
  } rod_ctrl_t;

  typedef struct packed {
    rod_ctrl_t ctrl;
    logic [6:0] win;
    logic inv;
    logic [3:0] bw;
    logic signed [5:0] lim_lo;
    logic signed [5:0] lim_hi;
    logic signed [5:0] corr;
    logic signed [31:0] integ;
    logic [3:0] decay_code;
    logic [3:0] nf_code;
    logic [7:0] thr_lo;
    logic [7:0] thr_hi;
    logic [4:0] hold_en;
    logic [2:0] force_hold;
    logic [15:0] start_dly;
    logic [15:0] stop_dly;
    logic [15:0] fast_len;
    logic [1:0] fast_sel;
    logic [3:0] int_mask;
    logic signed [15:0] nf;
    logic signed [31:0] pk_max;
    logic signed [31:0] pk_min;
    logic raw;
    logic proc;
    logic [15:0] dcnt;
    logic [15:0] fast_cnt;
    logic event_pulse;
    logic ack;
    logic [31:0] rdata;
  } rod_state_t;

endpackage : rod_pkg
`default_nettype wire
